//--- common/pmmd_defines.svh
// Purpose: Constants for the parameter map mirror decode block
// Assumes: Relative register addresses, 16-bit registers
// Notes: Offsets, limits, reset values and codes
//
// Summary of operation
// - Base region reads round to nearest integer, raw digits when linear except the filter
// - Addresses 1000-1999 mirror base times ten, unscaled when linear except the filter
// - Addresses 8000-9999 give float pairs
// - Linear input imposes decimal places, except on the filter
// - Linear decimal position at most three
// - Temperature decimals only where value fits
// - Sensor range, else scaling limits when linear
// - Baud codes 2-7 map 300-9600, reset 7
// - Word order selects float register order
// - Process value at base address zero
// - Integer parameters have no mirrors
// - Tenfold read keeps low 16 bits of ten times value
// - Single register results wrap at 16 bits
`ifndef PMMD_DEFINES_SVH
`define PMMD_DEFINES_SVH
// ==========================================
// Regions
`define PMMD_BASE_HI 16'h03e7
`define PMMD_TEN_LO 16'h03e8
`define PMMD_TEN_HI 16'h07cf
`define PMMD_FLT_LO 16'h1f40
`define PMMD_FLT_HI 16'h270f
`define PMMD_PV_OFF 16'h0000
`define PMMD_PAR_OFF 16'h0018
// ==========================================
// Integer registers
`define PMMD_INTYPE_ADDR 16'h0fd1
`define PMMD_DECPOS_ADDR 16'h0fe5
`define PMMD_PROTO_ADDR 16'h0ff0
`define PMMD_STN_ADDR 16'h0ff1
`define PMMD_BAUD_ADDR 16'h0ff2
`define PMMD_PARITY_ADDR 16'h0ff3
`define PMMD_ORDER_ADDR 16'h0ff4
// ==========================================
// Values, limits, resets
`define PMMD_LIN_FIRST 8'h0d
`define PMMD_INTYPE_MAX 8'h16
`define PMMD_INTYPE_RST 8'h03
`define PMMD_DP_MAX_LIN 2'h3
`define PMMD_DP_MAX_TMP 2'h2
`define PMMD_PROTO_VAL 16'h0004
`define PMMD_STN_RST 8'h01
`define PMMD_STN_MAX 16'h00f7
`define PMMD_BAUD_MIN 16'h0002
`define PMMD_BAUD_MAX 16'h0007
`define PMMD_BAUD_RST 3'h7
`define PMMD_PARITY_MAX 16'h0002
`define PMMD_ORDER_RST 1'b1
`define PMMD_NOM_LO (-32'sh000007cf)
`define PMMD_NOM_HI 32'sh0000270f
`define PMMD_BIAS_LIM 32'sh000003e8
`define PMMD_SENS_LO (-32'sh00000148)
`define PMMD_SENS_HI 32'sh00000578
`define PMMD_FILT_LO 32'sh00000001
`define PMMD_FILT_HI 32'sh00000064
`define PMMD_SCL_LO_RST 16'hf831
`define PMMD_SCL_HI_RST 16'h270f
`define PMMD_SP_LO_RST 16'hfeb8
`define PMMD_SP_HI_RST 16'h0578
`define PMMD_FILT_RST 16'h0005
`define PMMD_EXC_ADDR 8'h02
`define PMMD_EXC_VAL 8'h03
`endif

//--- common/pmmd_pkg.sv
// Purpose: Types for the parameter map mirror decode block
// Assumes: Used with pmmd_defines.svh
// Notes: Request and answer travel as packed structs
package pmmd_pkg;
  typedef enum logic [1:0] {PMMD_IDLE, PMMD_CHECK, PMMD_READ} pmmd_state_t;
  typedef enum logic [2:0] {RG_NONE, RG_BASE, RG_TEN, RG_FLT, RG_INT} pmmd_region_t;
  typedef struct packed {
    pmmd_region_t rg;
    logic [2:0] pi;
    logic half;
    logic [2:0] ri;
  } pmmd_dec_t;
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [7:0] qty;
    logic [15:0] wdata;
  } pmmd_req_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] exc;
    logic [15:0] data;
  } pmmd_rsp_t;
  typedef struct packed {
    logic [7:0] station;
    logic [2:0] baud_code;
    logic [13:0] baud_rate;
    logic [1:0] parity;
    logic word_order;
  } pmmd_comm_t;
  typedef struct packed {
    logic ok;
    logic [1:0] dp;
    logic signed [15:0] raw;
  } pmmd_fit_t;
endpackage

//--- logic/pmmd_float_conv.sv
// Purpose: Fixed-decimal value to single-precision bits
// Assumes: Divisor 10^dp, dp 0 to 3
// Notes: Mantissa is truncated, not rounded
`timescale 1ns/1ps
`default_nettype none
module pmmd_float_conv (
  input wire logic signed [15:0] i_raw,
  input wire logic [1:0] i_dp,
  output logic [31:0] o_bits
);
  logic [16:0] mag;
  logic [40:0] num;
  logic [40:0] q;
  logic [40:0] sh;
  logic [5:0] p;
  logic [7:0] ex;
  always_comb begin
    mag = i_raw[15] ? (17'h0 - {i_raw[15], i_raw}) : {1'b0, i_raw};
    num = {mag, 24'h000000};
    case (i_dp)
      2'h0: q = num;
      2'h1: q = num / 41'h00a;
      2'h2: q = num / 41'h064;
      default: q = num / 41'h3e8;
    endcase
    p = 6'h00;
    for (int i = 0; i < 41; i++) begin
      if (q[i]) begin
        p = 6'(i);
      end
    end
    sh = q << (6'h28 - p);
    // Bias 127 less the 24 fraction bits
    ex = {2'b00, p} + 8'h67;
    o_bits = (q == 41'h0) ? 32'h0 : {i_raw[15], ex, sh[39:17]};
  end
endmodule
`default_nettype wire

//--- logic/pmmd_range_check.sv
// Purpose: Inclusive bound check of a parameter value
// Assumes: Signed 32-bit operands
// Notes: Combinational
`timescale 1ns/1ps
`default_nettype none
module pmmd_range_check (
  input wire logic signed [31:0] i_val,
  input wire logic signed [31:0] i_lo,
  input wire logic signed [31:0] i_hi,
  output logic o_ok
);
  assign o_ok = (i_val >= i_lo) && (i_val <= i_hi);
endmodule
`default_nettype wire

//--- logic/pmmd_top.sv
// Purpose: Register decode with base, tenfold and float mirrors
// Assumes: Protocol front end delivers decoded register requests
// Notes: One answer word per cycle; writes are single-register
`include "pmmd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pmmd_top import pmmd_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_req_valid,
  input wire pmmd_req_t i_req,
  input wire logic signed [15:0] i_pv_raw,
  input wire logic [1:0] i_pv_dp,
  output var pmmd_rsp_t o_rsp,
  output logic o_busy,
  output var pmmd_comm_t o_comm
);
  // ==========================================
  // Functions
  function automatic logic signed [31:0] pow10(input logic [1:0] d);
    case (d)
      2'h0: pow10 = 32'sh00000001;
      2'h1: pow10 = 32'sh0000000a;
      2'h2: pow10 = 32'sh00000064;
      default: pow10 = 32'sh000003e8;
    endcase
  endfunction

  // Half away from zero: 250.5 gives 251
  function automatic logic signed [31:0] rnd(input logic signed [31:0] v,
                                             input logic [1:0] d);
    logic signed [31:0] m;
    logic signed [31:0] q;
    m = (v < 0) ? -v : v;
    q = (m + (pow10(d) >>> 1)) / pow10(d);
    rnd = (v < 0) ? -q : q;
  endfunction

  function automatic pmmd_dec_t decode(input logic [15:0] a);
    pmmd_dec_t r;
    logic [15:0] off;
    r.rg = RG_NONE;
    r.pi = 3'h0;
    r.half = 1'b0;
    r.ri = 3'h0;
    off = 16'hffff;
    if (a >= `PMMD_FLT_LO && a <= `PMMD_FLT_HI) begin
      off = (a - `PMMD_FLT_LO) >> 1;
      r.half = a[0];
      r.rg = RG_FLT;
    end else if (a >= `PMMD_TEN_LO && a <= `PMMD_TEN_HI) begin
      off = a - `PMMD_TEN_LO;
      r.rg = RG_TEN;
    end else if (a <= `PMMD_BASE_HI) begin
      off = a;
      r.rg = RG_BASE;
    end
    // Only fractional parameters are mirrored
    if (r.rg != RG_NONE) begin
      if (off == `PMMD_PV_OFF) begin
        r.pi = 3'h0;
      end else if (off > `PMMD_PAR_OFF && off <= `PMMD_PAR_OFF + 16'h0006) begin
        r.pi = 3'(off - `PMMD_PAR_OFF);
      end else begin
        r.rg = RG_NONE;
      end
    end else begin
      r.rg = RG_INT;
      case (a)
        `PMMD_INTYPE_ADDR: r.ri = 3'h0;
        `PMMD_DECPOS_ADDR: r.ri = 3'h1;
        `PMMD_PROTO_ADDR: r.ri = 3'h2;
        `PMMD_STN_ADDR: r.ri = 3'h3;
        `PMMD_BAUD_ADDR: r.ri = 3'h4;
        `PMMD_PARITY_ADDR: r.ri = 3'h5;
        `PMMD_ORDER_ADDR: r.ri = 3'h6;
        default: r.rg = RG_NONE;
      endcase
    end
    decode = r;
  endfunction

  // Highest decimal count, up to dps, that keeps the stored digits in range
  function automatic pmmd_fit_t fit(input logic signed [31:0] v, input logic k,
                                    input logic [1:0] dps);
    pmmd_fit_t r;
    logic signed [31:0] s;
    r.ok = 1'b0;
    r.dp = 2'h0;
    r.raw = 16'sh0000;
    for (int d = 3; d >= 0; d--) begin
      if (!r.ok && 2'(d) <= dps) begin
        s = (d >= int'(k)) ? v * pow10(2'(d - int'(k))) : rnd(v, 2'h1);
        if (s >= `PMMD_NOM_LO && s <= `PMMD_NOM_HI) begin
          r.ok = 1'b1;
          r.dp = 2'(d);
          r.raw = 16'(s);
        end
      end
    end
    fit = r;
  endfunction

  function automatic logic [13:0] baud_of(input logic [2:0] c);
    case (c)
      3'h2: baud_of = 14'h012c;
      3'h3: baud_of = 14'h0258;
      3'h4: baud_of = 14'h04b0;
      3'h5: baud_of = 14'h0960;
      3'h6: baud_of = 14'h12c0;
      default: baud_of = 14'h2580;
    endcase
  endfunction

  // ==========================================
  // State
  pmmd_state_t st_q;
  logic [15:0] cur_q;
  logic [15:0] start_q;
  logic [7:0] cnt_q;
  logic [7:0] qty_q;
  logic signed [15:0] par_raw_q [1:6];
  logic [1:0] par_dp_q [1:6];
  logic [7:0] in_type_q;
  logic [1:0] dp_set_q;
  logic [7:0] station_q;
  logic [2:0] baud_q;
  logic [1:0] parity_q;
  logic order_q;
  pmmd_rsp_t rsp_q;
  pmmd_comm_t comm_q;

  pmmd_dec_t cur_dec;
  pmmd_dec_t req_dec;
  logic lin;
  logic sel_lin;
  logic signed [15:0] sel_raw;
  logic [1:0] sel_dp;
  logic [31:0] flt_bits;
  logic [15:0] rd_word;
  logic signed [31:0] rb;
  logic signed [31:0] rt;
  logic [15:0] req_end;
  pmmd_dec_t end_dec;
  logic start_bad;
  logic wr_go;
  logic rd_go;
  logic [7:0] wr_exc;
  logic w_lin;
  pmmd_fit_t wfit;
  logic signed [31:0] w_eng;
  logic signed [31:0] w_lo;
  logic signed [31:0] w_hi;
  logic w_rng_ok;
  logic signed [31:0] wv;

  assign lin = in_type_q >= `PMMD_LIN_FIRST;
  assign cur_dec = decode(cur_q);
  assign req_dec = decode(i_req.addr);
  assign wr_go = (st_q == PMMD_IDLE) && i_req_valid && i_req.write;
  assign rd_go = (st_q == PMMD_IDLE) && i_req_valid && !i_req.write;
  // Write data is signed digits, so widen it with its sign bit
  assign wv = {{16{i_req.wdata[15]}}, i_req.wdata};

  // ==========================================
  // Read path
  // Filter value is always held with its decimal point
  assign sel_lin = lin && (cur_dec.pi != 3'h6);
  assign sel_raw = (cur_dec.pi == 3'h0) ? i_pv_raw : par_raw_q[cur_dec.pi];
  assign sel_dp = (cur_dec.pi == 3'h0) ? i_pv_dp : par_dp_q[cur_dec.pi];
  assign rb = rnd(32'(sel_raw), sel_dp);
  assign rt = rnd(32'(sel_raw) * 32'sh0000000a, sel_dp);

  pmmd_float_conv u_flt (
    .i_raw(sel_raw),
    .i_dp(sel_lin ? 2'h0 : sel_dp),
    .o_bits(flt_bits)
  );

  always_comb begin
    rd_word = 16'h0000;
    case (cur_dec.rg)
      RG_BASE: rd_word = sel_lin ? sel_raw : rb[15:0];
      // Linear values carry their digits unchanged; tenfold wraps at 16 bits
      RG_TEN: rd_word = sel_lin ? sel_raw : rt[15:0];
      RG_FLT: rd_word = (cur_dec.half ^ order_q) ? flt_bits[15:0] : flt_bits[31:16];
      RG_INT: begin
        case (cur_dec.ri)
          3'h0: rd_word = {8'h00, in_type_q};
          3'h1: rd_word = {14'h0000, dp_set_q};
          3'h2: rd_word = `PMMD_PROTO_VAL;
          3'h3: rd_word = {8'h00, station_q};
          3'h4: rd_word = {13'h0000, baud_q};
          3'h5: rd_word = {14'h0000, parity_q};
          default: rd_word = {15'h0000, order_q};
        endcase
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // Pair must start even and end odd so both halves go out together
  assign req_end = i_req.addr + {8'h00, i_req.qty} - 16'h0001;
  assign end_dec = decode(req_end);
  assign start_bad = (req_dec.rg == RG_FLT && i_req.addr[0]) ||
                     (end_dec.rg == RG_FLT && !req_end[0]);

  // ==========================================
  // Write checks
  assign w_lin = lin && (req_dec.pi != 3'h6);
  always_comb begin
    if (w_lin) begin
      wfit.ok = (wv >= `PMMD_NOM_LO) && (wv <= `PMMD_NOM_HI);
      wfit.dp = dp_set_q;
      wfit.raw = i_req.wdata;
    end else begin
      wfit = fit(wv, req_dec.rg == RG_TEN, dp_set_q);
    end
    w_eng = w_lin ? 32'(wfit.raw) : rnd(32'(wfit.raw), wfit.dp);
    if (wfit.raw[15]) begin
      w_eng[31:16] = w_lin ? 16'hffff : w_eng[31:16];
    end
    case (req_dec.pi)
      3'h1: begin
        w_lo = -`PMMD_BIAS_LIM;
        w_hi = `PMMD_BIAS_LIM;
      end
      3'h4, 3'h5: begin
        w_lo = lin ? 32'(par_raw_q[2]) : `PMMD_SENS_LO;
        w_hi = lin ? 32'(par_raw_q[3]) : `PMMD_SENS_HI;
        if (lin && par_raw_q[2][15]) begin
          w_lo[31:16] = 16'hffff;
        end
        if (lin && par_raw_q[3][15]) begin
          w_hi[31:16] = 16'hffff;
        end
      end
      3'h6: begin
        w_lo = `PMMD_FILT_LO;
        w_hi = `PMMD_FILT_HI;
      end
      default: begin
        w_lo = `PMMD_NOM_LO;
        w_hi = `PMMD_NOM_HI;
      end
    endcase
  end

  pmmd_range_check u_rng (
    .i_val(w_eng),
    .i_lo(w_lo),
    .i_hi(w_hi),
    .o_ok(w_rng_ok)
  );

  always_comb begin
    wr_exc = 8'h00;
    if (i_req.qty != 8'h01) begin
      wr_exc = `PMMD_EXC_VAL;
    end else begin
      case (req_dec.rg)
        RG_BASE, RG_TEN: begin
          if (req_dec.pi == 3'h0) begin
            wr_exc = `PMMD_EXC_ADDR;
          end else if (!wfit.ok || !w_rng_ok) begin
            wr_exc = `PMMD_EXC_VAL;
          end
        end
        RG_INT: begin
          case (req_dec.ri)
            3'h0: wr_exc = (i_req.wdata > {8'h00, `PMMD_INTYPE_MAX}) ? `PMMD_EXC_VAL : 8'h00;
            3'h1: wr_exc = (i_req.wdata > {14'h0000, lin ? `PMMD_DP_MAX_LIN : `PMMD_DP_MAX_TMP})
                           ? `PMMD_EXC_VAL : 8'h00;
            3'h2: wr_exc = `PMMD_EXC_ADDR;
            3'h3: wr_exc = (i_req.wdata == 16'h0000 || i_req.wdata > `PMMD_STN_MAX)
                           ? `PMMD_EXC_VAL : 8'h00;
            3'h4: wr_exc = (i_req.wdata < `PMMD_BAUD_MIN || i_req.wdata > `PMMD_BAUD_MAX)
                           ? `PMMD_EXC_VAL : 8'h00;
            3'h5: wr_exc = (i_req.wdata > `PMMD_PARITY_MAX) ? `PMMD_EXC_VAL : 8'h00;
            default: wr_exc = (i_req.wdata > 16'h0001) ? `PMMD_EXC_VAL : 8'h00;
          endcase
        end
        // Float-region writes are not accepted; floats are read-only here
        default: wr_exc = `PMMD_EXC_ADDR;
      endcase
    end
  end

  // ==========================================
  // Sequencer
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      st_q <= PMMD_IDLE;
      cur_q <= 16'h0000;
      start_q <= 16'h0000;
      cnt_q <= 8'h00;
      qty_q <= 8'h00;
    end else begin
      case (st_q)
        PMMD_IDLE: begin
          if (rd_go && !start_bad && i_req.qty != 8'h00) begin
            st_q <= PMMD_CHECK;
            cur_q <= i_req.addr;
            start_q <= i_req.addr;
            cnt_q <= i_req.qty;
            qty_q <= i_req.qty;
          end
        end
        // Whole span is checked before any word goes out
        PMMD_CHECK: begin
          if (cur_dec.rg == RG_NONE) begin
            st_q <= PMMD_IDLE;
          end else if (cnt_q == 8'h01) begin
            st_q <= PMMD_READ;
            cur_q <= start_q;
            cnt_q <= qty_q;
          end else begin
            cur_q <= cur_q + 16'h0001;
            cnt_q <= cnt_q - 8'h01;
          end
        end
        PMMD_READ: begin
          cur_q <= cur_q + 16'h0001;
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q <= PMMD_IDLE;
          end
        end
        default: st_q <= PMMD_IDLE;
      endcase
    end
  end

  // ==========================================
  // Answer
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= 1'b0;
      rsp_q.last <= 1'b0;
      rsp_q.exc <= 8'h00;
      if (wr_go) begin
        rsp_q <= '{valid: 1'b1, last: 1'b1, exc: wr_exc, data: i_req.wdata};
      end else if (rd_go && (start_bad || i_req.qty == 8'h00)) begin
        rsp_q <= '{valid: 1'b1, last: 1'b1, data: 16'h0000,
                   exc: start_bad ? `PMMD_EXC_ADDR : `PMMD_EXC_VAL};
      end else if (st_q == PMMD_CHECK && cur_dec.rg == RG_NONE) begin
        rsp_q <= '{valid: 1'b1, last: 1'b1, exc: `PMMD_EXC_ADDR, data: 16'h0000};
      end else if (st_q == PMMD_READ) begin
        rsp_q <= '{valid: 1'b1, last: cnt_q == 8'h01, exc: 8'h00, data: rd_word};
      end
    end
  end

  // ==========================================
  // Parameter store
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      par_raw_q[1] <= 16'sh0000;
      par_raw_q[2] <= `PMMD_SCL_LO_RST;
      par_raw_q[3] <= `PMMD_SCL_HI_RST;
      par_raw_q[4] <= `PMMD_SP_LO_RST;
      par_raw_q[5] <= `PMMD_SP_HI_RST;
      par_raw_q[6] <= `PMMD_FILT_RST;
      for (int i = 1; i <= 6; i++) begin
        par_dp_q[i] <= 2'h0;
      end
    end else if (wr_go && wr_exc == 8'h00 && req_dec.rg != RG_INT) begin
      par_raw_q[req_dec.pi] <= wfit.raw;
      par_dp_q[req_dec.pi] <= wfit.dp;
    end
  end

  // ==========================================
  // Integer and link settings
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      in_type_q <= `PMMD_INTYPE_RST;
      dp_set_q <= 2'h0;
      station_q <= `PMMD_STN_RST;
      baud_q <= `PMMD_BAUD_RST;
      parity_q <= 2'h0;
      order_q <= `PMMD_ORDER_RST;
    end else if (wr_go && wr_exc == 8'h00 && req_dec.rg == RG_INT) begin
      case (req_dec.ri)
        3'h0: in_type_q <= i_req.wdata[7:0];
        3'h1: dp_set_q <= i_req.wdata[1:0];
        3'h3: station_q <= i_req.wdata[7:0];
        3'h4: baud_q <= i_req.wdata[2:0];
        3'h5: parity_q <= i_req.wdata[1:0];
        3'h6: order_q <= i_req.wdata[0];
        default: order_q <= order_q;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      comm_q <= '{station: `PMMD_STN_RST, baud_code: `PMMD_BAUD_RST,
                  baud_rate: 14'h2580, parity: 2'h0, word_order: `PMMD_ORDER_RST};
    end else begin
      comm_q <= '{station: station_q, baud_code: baud_q, baud_rate: baud_of(baud_q),
                  parity: parity_q, word_order: order_q};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (st_q != PMMD_IDLE) || rd_go;
    end
  end

  assign o_rsp = rsp_q;
  assign o_comm = comm_q;

  // ==========================================
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence s_exc(logic [7:0] c);
    ##1 (o_rsp.valid && o_rsp.exc == c);
  endsequence

  chk_base_round: assert property (
    (st_q == PMMD_READ && cur_dec.rg == RG_BASE && !sel_lin && sel_dp == 2'h0)
    |=> (o_rsp.data == $past(sel_raw))) else $error("base word not the stored integer");
  chk_ten_tenths: assert property (
    (st_q == PMMD_READ && cur_dec.rg == RG_TEN && !sel_lin && sel_dp == 2'h1)
    |=> (o_rsp.data == $past(sel_raw))) else $error("tenfold word wrong");
  chk_flt_order: assert property (
    (st_q == PMMD_READ && cur_dec.rg == RG_FLT && !cur_dec.half && !order_q)
    |=> (o_rsp.data == $past(flt_bits[31:16]))) else $error("float word order wrong");
  chk_pv_mirror: assert property (
    (st_q == PMMD_READ && cur_q == `PMMD_TEN_LO && !lin && i_pv_dp == 2'h1)
    |=> (o_rsp.data == $past(i_pv_raw))) else $error("process value mirror wrong");
  chk_flt_odd: assert property (
    (rd_go && req_dec.rg == RG_FLT && i_req.addr[0])
    |-> s_exc(`PMMD_EXC_ADDR)) else $error("odd float start accepted");
  chk_dp_limit: assert property (
    (wr_go && i_req.addr == `PMMD_DECPOS_ADDR && i_req.wdata == 16'h0003 && !lin)
    |-> s_exc(`PMMD_EXC_VAL)) else $error("temperature decimal position 3 accepted");
  chk_dp_impose: assert property (
    (wr_go && req_dec.rg == RG_BASE && req_dec.pi == 3'h2 && lin && wr_exc == 8'h00)
    |=> (par_dp_q[2] == $past(dp_set_q))) else $error("linear decimals not imposed");
  chk_scale_bound: assert property (
    (wr_go && req_dec.rg == RG_BASE && req_dec.pi == 3'h4 && lin && i_req.qty == 8'h01 &&
     $signed(i_req.wdata) > par_raw_q[3]) |-> s_exc(`PMMD_EXC_VAL))
    else $error("value above scaling limit accepted");
  chk_int_only: assert property (
    (rd_go && i_req.addr == `PMMD_INTYPE_ADDR + `PMMD_TEN_LO && i_req.qty == 8'h01)
    |-> ##[1:2] (o_rsp.valid && o_rsp.exc == `PMMD_EXC_ADDR))
    else $error("unmirrored address answered");
  chk_baud_map: assert property (
    (baud_q == 3'h7) |=> (o_comm.baud_rate == 14'h2580)) else $error("code 7 not 9600");
endmodule
`default_nettype wire

//--- verification/pmmd_master_model.sv
// Purpose: Register-protocol master that polls the decode block
// Assumes: One request at a time; answer words kept in order
// Notes: Released request fields are inverted so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module pmmd_master_model import pmmd_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_busy,
  input wire pmmd_rsp_t i_rsp,
  output logic o_req_valid,
  output var pmmd_req_t o_req
);
  logic [15:0] words [0:7];
  logic [7:0] exc;
  int nwords;
  initial begin
    o_req_valid = 1'b0;
    o_req = '0;
  end
  // ==========================================
  // Request and answer collection
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] q,
                      input logic [15:0] wd);
    int n;
    n = 0;
    nwords = 0;
    exc = 8'hff;
    while (i_busy !== 1'b0 && n < 600) begin
      @(posedge i_mclk) #1;
      n++;
    end
    o_req_valid = 1'b1;
    o_req = '{write: w, addr: a, qty: q, wdata: wd};
    @(posedge i_mclk) #1;
    o_req_valid = 1'b0;
    o_req = ~o_req;
    n = 0;
    while (n < 600) begin
      if (i_rsp.valid === 1'b1) begin
        if (nwords < 8) words[nwords] = i_rsp.data;
        nwords++;
        exc = i_rsp.exc;
        if (i_rsp.last === 1'b1) break;
      end
      @(posedge i_mclk) #1;
      n++;
    end
    // Gap so the next request lands after the last word
    @(posedge i_mclk) #1;
  endtask
  // Both halves of a float always go in one request
  task automatic rd_float(input logic [15:0] a);
    xfer(1'b0, a, 8'h02, 16'h0000);
  endtask
endmodule
`default_nettype wire

//--- verification/test_parameter_map_mirror_decode.sv
// Purpose: Self-checking bench for the register decode block
// Assumes: Master model issues every request
// Notes: Expected values worked out by hand from the register map
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", s, e, g); end end
module test_parameter_map_mirror_decode import pmmd_pkg::*; ;
  logic i_mclk, i_reset, req_valid, busy;
  pmmd_req_t req;
  pmmd_rsp_t rsp;
  pmmd_comm_t comm;
  logic signed [15:0] pv_raw;
  logic [1:0] pv_dp;
  int errors = 0;
  int checks = 0;
  logic [15:0] rv [5] = '{16'h0004, 16'h0001, 16'h0007, 16'h0000, 16'h0001};
  int br [6] = '{300, 600, 1200, 2400, 4800, 9600};
  pmmd_top DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_req_valid(req_valid), .i_req(req),
    .i_pv_raw(pv_raw), .i_pv_dp(pv_dp), .o_rsp(rsp), .o_busy(busy), .o_comm(comm));
  pmmd_master_model M (.i_mclk(i_mclk), .i_busy(busy), .i_rsp(rsp), .o_req_valid(req_valid),
    .o_req(req));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // ==========================================
  // Access tasks
  task automatic rd1(input string s, input logic [15:0] a, input logic [15:0] e);
    M.xfer(1'b0, a, 8'h01, 16'h0000);
    `CHK(s, e, M.words[0])
  endtask
  task automatic ex(input logic w, input logic [15:0] a, input logic [7:0] q,
                    input logic [15:0] d, input logic [7:0] e);
    M.xfer(w, a, q, d);
    `CHK("exc", e, M.exc)
  endtask
  task automatic stop_test();
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    i_reset = 1'b1;
    pv_raw = 16'sh09c8;
    pv_dp = 2'h1;
    repeat (8) @(posedge i_mclk);
    #1 i_reset = 1'b0;
    M.xfer(1'b0, 16'h0ff0, 8'h05, 16'h0000);
    for (int i = 0; i < 5; i++) `CHK("link", rv[i], M.words[i])
    `CHK("rate", 14'h2580, comm.baud_rate)
    `CHK("comm", {8'h01, 3'h7, 14'h2580, 2'h0, 1'b1}, comm)
    for (int c = 2; c < 8; c++) begin
      ex(1'b1, 16'h0ff2, 8'h01, 16'(c), 8'h00);
      `CHK("rate", 14'(br[c - 2]), comm.baud_rate)
      `CHK("code", 3'(c), comm.baud_code)
    end
    ex(1'b1, 16'h0ff2, 8'h01, 16'h0008, 8'h03);
    ex(1'b1, 16'h0ff2, 8'h01, 16'h0001, 8'h03);
    rd1("pv", 16'h0000, 16'h00fa);
    rd1("pv10", 16'h03e8, 16'h09c8);
    M.rd_float(16'h1f40);
    `CHK("flo", 16'h6666, M.words[0])
    `CHK("fhi", 16'h437a, M.words[1])
    ex(1'b1, 16'h0ff4, 8'h01, 16'h0000, 8'h00);
    `CHK("order", 1'b0, comm.word_order)
    M.rd_float(16'h1f40);
    `CHK("fhi", 16'h437a, M.words[0])
    `CHK("flo", 16'h6666, M.words[1])
    pv_raw = 16'sh09c9;
    rd1("pvr", 16'h0000, 16'h00fb);
    pv_raw = 16'sh270f;
    pv_dp = 2'h0;
    rd1("wrap", 16'h03e8, 16'h8696);
    ex(1'b0, 16'h1f41, 8'h02, 16'h0000, 8'h02);
    ex(1'b0, 16'h1f40, 8'h01, 16'h0000, 8'h02);
    ex(1'b1, 16'h1f40, 8'h01, 16'h0000, 8'h02);
    ex(1'b0, 16'h13b9, 8'h01, 16'h0000, 8'h02);
    ex(1'b1, 16'h0019, 8'h02, 16'h0000, 8'h03);
    // Temperature input: decimals are only a ceiling
    ex(1'b1, 16'h0fe5, 8'h01, 16'h0003, 8'h03);
    ex(1'b1, 16'h0fe5, 8'h01, 16'h0001, 8'h00);
    ex(1'b1, 16'h0401, 8'h01, 16'h007d, 8'h00);
    rd1("bias", 16'h0019, 16'h000d);
    rd1("bias10", 16'h0401, 16'h007d);
    ex(1'b1, 16'h0fe5, 8'h01, 16'h0002, 8'h00);
    ex(1'b1, 16'h001b, 8'h01, 16'h1f40, 8'h00);
    rd1("shi", 16'h001b, 16'h1f40);
    ex(1'b1, 16'h001c, 8'h01, 16'h05dc, 8'h03);
    // Linear input: scaling limits bound sensor-range parameters
    ex(1'b1, 16'h0fd1, 8'h01, 16'h000d, 8'h00);
    ex(1'b1, 16'h0fe5, 8'h01, 16'h0003, 8'h00);
    ex(1'b1, 16'h0fe5, 8'h01, 16'h0004, 8'h03);
    ex(1'b1, 16'h001a, 8'h01, 16'hfc18, 8'h00);
    rd1("slo", 16'h001a, 16'hfc18);
    ex(1'b1, 16'h001b, 8'h01, 16'h01f4, 8'h00);
    ex(1'b1, 16'h001c, 8'h01, 16'h0258, 8'h03);
    ex(1'b1, 16'h001c, 8'h01, 16'h0190, 8'h00);
    stop_test();
  end
  // Whole run is well under a thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
